// ==== hw/hbf_consts.vh ====
// Constants shared by the bit-oriented framer
`ifndef HBF_CONSTS_VH
`define HBF_CONSTS_VH

`define HBF_FLAG        8'h7E
`define HBF_MARK_BYTE   8'hFF
`define HBF_RUN_STUFF   3'h5
`define HBF_RUN_FLAG    3'h6
`define HBF_RUN_SAT     3'h7
`define HBF_RUN_ZERO    3'h7

`define HBF_CRC_NONE    2'h0
`define HBF_CRC_8       2'h1
`define HBF_CRC_16      2'h2
`define HBF_CRC_32      2'h3

`define HBF_POLY8       32'h000000E0
`define HBF_POLY16      32'h00008408
`define HBF_POLY32      32'hEDB88320
`define HBF_MASK8       32'h000000FF
`define HBF_MASK16      32'h0000FFFF
`define HBF_MASK32      32'hFFFFFFFF
`define HBF_GOOD8       32'h000000CF
`define HBF_GOOD16      32'h0000F0B8
`define HBF_GOOD32      32'hDEBB20E3

`define HBF_MIN_BYTES8  3'h2
`define HBF_MIN_BYTES16 3'h3
`define HBF_MIN_BYTES32 3'h5
`define HBF_MAX_FRAME   16'hFFFD

`define HBF_ADDR_OFF    2'h0
`define HBF_ADDR_8      2'h1
`define HBF_ADDR_16     2'h2
`define HBF_ALL_STATION 8'hFF
`define HBF_NO_STATION  8'h00

`define HBF_ST_VFR      0
`define HBF_ST_CRC      1
`define HBF_ST_ABF      2
`define HBF_ST_LEN      3
`define HBF_ST_RST      4

`endif

// ==== hw/hbf_framer.v ====
// Bit-oriented HDLC framer: serial transmitter and receiver for one channel
`include "hbf_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module hbf_framer (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        rx_clk,
    input  wire        rx_data,
    input  wire        tx_clk,
    output reg         tx_data_q,
    input  wire        cts_n,
    input  wire        txq_valid,
    input  wire [7:0]  txq_data,
    input  wire        txq_last,
    output reg         txq_ready,
    output reg         rxq_valid_q,
    output reg  [7:0]  rxq_data_q,
    output reg         rxq_status_q,
    input  wire [1:0]  cfg_crc_sel,
    input  wire        cfg_one_ins,
    input  wire [1:0]  cfg_addr_mode,
    input  wire        cfg_addr_fwd,
    input  wire [15:0] cfg_station_addr,
    input  wire [15:0] cfg_station_mask,
    input  wire [15:0] cfg_group_addr,
    input  wire [15:0] cfg_group_mask,
    input  wire        cfg_rlc_en,
    input  wire [15:0] cfg_rlc_len,
    input  wire        cfg_cts_en,
    input  wire        cfg_fill_marks,
    input  wire        rx_reset_cmd,
    input  wire        stat_clear,
    output reg         stat_crc_err_q,
    output reg         stat_abort_q,
    output wire        rx_synced
);

    localparam [5:0] TS_FILL  = 6'h01;
    localparam [5:0] TS_OPEN  = 6'h02;
    localparam [5:0] TS_DATA  = 6'h04;
    localparam [5:0] TS_CRC   = 6'h08;
    localparam [5:0] TS_CLOSE = 6'h10;
    localparam [5:0] TS_ABORT = 6'h20;
    localparam [2:0] RS_HUNT  = 3'h1;
    localparam [2:0] RS_ADDR  = 3'h2;
    localparam [2:0] RS_DATA  = 3'h4;

    function [31:0] crc_poly(input [1:0] sel);
        case (sel)
            `HBF_CRC_8:  crc_poly = `HBF_POLY8;
            `HBF_CRC_32: crc_poly = `HBF_POLY32;
            default:     crc_poly = `HBF_POLY16;
        endcase
    endfunction

    function [31:0] crc_init(input [1:0] sel);
        case (sel)
            `HBF_CRC_8:  crc_init = `HBF_MASK8;
            `HBF_CRC_32: crc_init = `HBF_MASK32;
            default:     crc_init = `HBF_MASK16;
        endcase
    endfunction

    // LSB-first update over one byte; the register is preset to all ones
    function [31:0] crc_byte(input [31:0] c, input [7:0] d, input [1:0] sel);
        integer i;
        reg     fb;
        begin
            crc_byte = c;
            for (i = 0; i < 8; i = i + 1) begin
                fb = crc_byte[0] ^ d[i];
                crc_byte = {1'b0, crc_byte[31:1]} ^ (fb ? crc_poly(sel) : 32'h00000000);
            end
        end
    endfunction

    function addr_ok(input [7:0] first, input [15:0] v, input wide);
        reg st;
        reg gr;
        begin
            if (wide) begin
                st = ((v ^ cfg_station_addr) & ~cfg_station_mask) == 16'h0000;
                gr = ((v ^ cfg_group_addr) & ~cfg_group_mask) == 16'h0000;
            end else begin
                st = ((v[7:0] ^ cfg_station_addr[7:0]) & ~cfg_station_mask[7:0]) == 8'h00;
                gr = ((v[7:0] ^ cfg_group_addr[7:0]) & ~cfg_group_mask[7:0]) == 8'h00;
            end
            if (first == `HBF_NO_STATION)
                addr_ok = 1'b0;
            else
                addr_ok = (first == `HBF_ALL_STATION) | st | gr;
        end
    endfunction

    // Pin synchronisers: rx_clk, rx_data, tx_clk, cts_n
    reg  [3:0] pin_s1_q;
    reg  [3:0] pin_s2_q;
    reg        rxc_prev_q;
    reg        txc_prev_q;
    wire       rx_rise = pin_s2_q[0] & ~rxc_prev_q;
    wire       rx_bit  = pin_s2_q[1];
    wire       tx_fall = ~pin_s2_q[2] & txc_prev_q;
    wire       cts_ok  = ~cfg_cts_en | ~pin_s2_q[3];

    // Transmitter
    reg [5:0]  ts_q, ts_d;
    reg [7:0]  tsh_q, tsh_d;
    reg [2:0]  tbcnt_q, tbcnt_d;
    reg [2:0]  tones_q, tones_d;
    reg [2:0]  tzeros_q, tzeros_d;
    reg [31:0] tcrc_q, tcrc_d;
    reg        tlast_q, tlast_d;
    reg [2:0]  tk_q, tk_d;
    reg        tbit_d;
    reg [2:0]  crc_nbytes;
    wire [7:0] fill_byte = cfg_fill_marks ? `HBF_MARK_BYTE : `HBF_FLAG;
    wire       start_ok  = txq_valid & cts_ok;

    always @* begin
        case (cfg_crc_sel)
            `HBF_CRC_8:  crc_nbytes = 3'h1;
            `HBF_CRC_16: crc_nbytes = 3'h2;
            `HBF_CRC_32: crc_nbytes = 3'h4;
            default:     crc_nbytes = 3'h0;
        endcase
    end

    always @* begin
        ts_d = ts_q;
        tsh_d = tsh_q;
        tbcnt_d = tbcnt_q;
        tones_d = tones_q;
        tzeros_d = tzeros_q;
        tcrc_d = tcrc_q;
        tlast_d = tlast_q;
        tk_d = tk_q;
        tbit_d = tx_data_q;
        txq_ready = 1'b0;
        if (tx_fall) begin
            if (tones_q == `HBF_RUN_STUFF) begin
                tbit_d = 1'b0;
                tones_d = 3'h0;
                tzeros_d = 3'h0;
            end else if (cfg_one_ins && tzeros_q == `HBF_RUN_ZERO) begin
                tbit_d = 1'b1;
                tones_d = 3'h0;
                tzeros_d = 3'h0;
            end else begin
                tbit_d = tsh_q[0];
                tsh_d = {1'b0, tsh_q[7:1]};
                tbcnt_d = tbcnt_q + 3'h1;
                if ((ts_q == TS_DATA) || (ts_q == TS_CRC)) begin
                    tones_d = tsh_q[0] ? tones_q + 3'h1 : 3'h0;
                    tzeros_d = tsh_q[0] ? 3'h0 :
                               (tzeros_q == `HBF_RUN_ZERO ? tzeros_q : tzeros_q + 3'h1);
                end else begin
                    tones_d = 3'h0;
                    tzeros_d = 3'h0;
                end
                if (tbcnt_q == 3'h7) begin
                    case (ts_q)
                        TS_FILL: begin
                            if (start_ok) begin
                                ts_d = TS_OPEN;
                                tsh_d = `HBF_FLAG;
                                tcrc_d = crc_init(cfg_crc_sel);
                            end else begin
                                tsh_d = fill_byte;
                            end
                        end
                        TS_OPEN, TS_DATA, TS_CLOSE: begin
                            if (ts_q == TS_DATA && tlast_q) begin
                                if (crc_nbytes == 3'h0) begin
                                    ts_d = TS_CLOSE;
                                    tsh_d = `HBF_FLAG;
                                end else begin
                                    ts_d = TS_CRC;
                                    tsh_d = ~tcrc_q[7:0];
                                    tcrc_d = {8'h00, tcrc_q[31:8]};
                                    tk_d = 3'h1;
                                end
                            end else if (ts_q == TS_CLOSE && !start_ok) begin
                                ts_d = TS_FILL;
                                tsh_d = fill_byte;
                            end else if (txq_valid) begin
                                // A frame started right after a closing flag shares it
                                ts_d = TS_DATA;
                                tsh_d = txq_data;
                                txq_ready = 1'b1;
                                tlast_d = txq_last;
                                tcrc_d = crc_byte((ts_q == TS_DATA) ? tcrc_q :
                                                  crc_init(cfg_crc_sel), txq_data, cfg_crc_sel);
                            end else begin
                                // Queue ran dry inside a frame: abort it
                                ts_d = TS_ABORT;
                                tsh_d = `HBF_MARK_BYTE;
                            end
                        end
                        TS_CRC: begin
                            if (tk_q < crc_nbytes) begin
                                tsh_d = ~tcrc_q[7:0];
                                tcrc_d = {8'h00, tcrc_q[31:8]};
                                tk_d = tk_q + 3'h1;
                            end else begin
                                ts_d = TS_CLOSE;
                                tsh_d = `HBF_FLAG;
                            end
                        end
                        default: begin
                            ts_d = TS_FILL;
                            tsh_d = fill_byte;
                        end
                    endcase
                end
            end
        end
    end

    // Receiver
    reg [2:0]  rs_q, rs_d;
    reg [2:0]  rones_q, rones_d;
    reg [2:0]  rzeros_q, rzeros_d;
    reg [2:0]  rbcnt_q, rbcnt_d;
    reg [7:0]  rsh_q, rsh_d;
    reg [31:0] rcrc_q, rcrc_d;
    reg [2:0]  rcnt_q, rcnt_d;
    reg [15:0] fcnt_q, fcnt_d;
    reg [7:0]  ahi_q, ahi_d;
    reg        afirst_q, afirst_d;
    reg        em0_v, em1_v;
    reg [8:0]  em0_d, em1_d;
    reg        set_crc, set_abf;
    reg [4:0]  sw;
    reg [2:0]  min_bytes;
    reg        pend_v_q;
    reg [8:0]  pend_d_q;
    wire [15:0] rlc_lim = (cfg_rlc_len > `HBF_MAX_FRAME) ? `HBF_MAX_FRAME : cfg_rlc_len;
    wire [2:0]  rs_start = (cfg_addr_mode == `HBF_ADDR_OFF) ? RS_DATA : RS_ADDR;
    wire        r_stuff1 = cfg_one_ins & (rzeros_q == `HBF_RUN_ZERO) & rx_bit;
    wire        crc_bad  = (cfg_crc_sel != `HBF_CRC_NONE) &&
                           (rcrc_q != (cfg_crc_sel == `HBF_CRC_8  ? `HBF_GOOD8 :
                                       cfg_crc_sel == `HBF_CRC_32 ? `HBF_GOOD32 : `HBF_GOOD16));

    assign rx_synced = ~rs_q[0];

    always @* begin
        case (cfg_crc_sel)
            `HBF_CRC_8:  min_bytes = `HBF_MIN_BYTES8;
            `HBF_CRC_32: min_bytes = `HBF_MIN_BYTES32;
            default:     min_bytes = `HBF_MIN_BYTES16;
        endcase
    end

    always @* begin
        rs_d = rs_q;
        rones_d = rones_q;
        rzeros_d = rzeros_q;
        rbcnt_d = rbcnt_q;
        rsh_d = rsh_q;
        rcrc_d = rcrc_q;
        rcnt_d = rcnt_q;
        fcnt_d = fcnt_q;
        ahi_d = ahi_q;
        afirst_d = afirst_q;
        em0_v = 1'b0;
        em0_d = 9'h000;
        em1_v = 1'b0;
        em1_d = 9'h000;
        set_crc = 1'b0;
        set_abf = 1'b0;
        sw = 5'h00;
        if (rx_reset_cmd && !rs_q[0]) begin
            sw[`HBF_ST_RST] = 1'b1;
            sw[`HBF_ST_CRC] = crc_bad;
            set_crc = crc_bad & (rcnt_q != 3'h0);
            em0_v = (rcnt_q != 3'h0);
            em0_d = {1'b1, 3'h0, sw};
            rs_d = RS_HUNT;
        end else if (rx_rise) begin
            rones_d = rx_bit ? (rones_q == `HBF_RUN_SAT ? rones_q : rones_q + 3'h1) : 3'h0;
            rzeros_d = rx_bit ? 3'h0 :
                       (rzeros_q == `HBF_RUN_ZERO ? rzeros_q : rzeros_q + 3'h1);
            if (rones_q == `HBF_RUN_STUFF && !rx_bit)
                rzeros_d = 3'h0;
            if (r_stuff1)
                rones_d = 3'h0;
            if (rones_q == `HBF_RUN_FLAG && !rx_bit) begin
                if (!rs_q[0] && rcnt_q != 3'h0) begin
                    sw[`HBF_ST_VFR] = (rbcnt_q == `HBF_RUN_FLAG) && (rcnt_q >= min_bytes)
                                      && rs_q[2];
                    sw[`HBF_ST_CRC] = crc_bad;
                    set_crc = crc_bad;
                    em0_v = 1'b1;
                    em0_d = {1'b1, 3'h0, sw};
                end
                rs_d = rs_start;
                rcrc_d = crc_init(cfg_crc_sel);
                rcnt_d = 3'h0;
                fcnt_d = 16'h0000;
                rbcnt_d = 3'h0;
                afirst_d = 1'b0;
            end else if (rones_q == `HBF_RUN_FLAG && rx_bit) begin
                if (!rs_q[0] && rcnt_q != 3'h0) begin
                    sw[`HBF_ST_ABF] = 1'b1;
                    sw[`HBF_ST_CRC] = crc_bad;
                    set_crc = crc_bad;
                    set_abf = 1'b1;
                    em0_v = 1'b1;
                    em0_d = {1'b1, 3'h0, sw};
                end
                rs_d = RS_HUNT;
            end else if (rones_q < `HBF_RUN_STUFF && !r_stuff1 && !rs_q[0]) begin
                // Deleted stuff bits and the sixth one never reach here
                rsh_d = {rx_bit, rsh_q[7:1]};
                rbcnt_d = rbcnt_q + 3'h1;
                if (rbcnt_q == 3'h7) begin
                    rcrc_d = crc_byte(rcrc_q, rsh_d, cfg_crc_sel);
                    rcnt_d = (rcnt_q == 3'h7) ? rcnt_q : rcnt_q + 3'h1;
                    if (rs_q[1]) begin
                        if (cfg_addr_mode == `HBF_ADDR_16 && !afirst_q) begin
                            ahi_d = rsh_d;
                            afirst_d = 1'b1;
                        end else if (cfg_addr_mode == `HBF_ADDR_16 &&
                                     addr_ok(ahi_q, {ahi_q, rsh_d}, 1'b1)) begin
                            rs_d = RS_DATA;
                            em0_v = cfg_addr_fwd;
                            em0_d = {1'b0, ahi_q};
                            em1_v = cfg_addr_fwd;
                            em1_d = {1'b0, rsh_d};
                            fcnt_d = cfg_addr_fwd ? fcnt_q + 16'h0002 : fcnt_q;
                        end else if (cfg_addr_mode != `HBF_ADDR_16 &&
                                     addr_ok(rsh_d, {8'h00, rsh_d}, 1'b0)) begin
                            rs_d = RS_DATA;
                            em0_v = cfg_addr_fwd;
                            em0_d = {1'b0, rsh_d};
                            fcnt_d = cfg_addr_fwd ? fcnt_q + 16'h0001 : fcnt_q;
                        end else begin
                            rs_d = RS_HUNT;
                        end
                    end else begin
                        em0_v = 1'b1;
                        em0_d = {1'b0, rsh_d};
                        fcnt_d = fcnt_q + 16'h0001;
                        if (cfg_rlc_en && fcnt_d == rlc_lim) begin
                            sw[`HBF_ST_LEN] = 1'b1;
                            em1_v = 1'b1;
                            em1_d = {1'b1, 3'h0, sw};
                            rs_d = RS_HUNT;
                        end
                    end
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            pin_s1_q <= 4'hF;
            pin_s2_q <= 4'hF;
            rxc_prev_q <= 1'b1;
            txc_prev_q <= 1'b1;
            ts_q <= TS_FILL;
            tsh_q <= `HBF_MARK_BYTE;
            tbcnt_q <= 3'h0;
            tones_q <= 3'h0;
            tzeros_q <= 3'h0;
            tcrc_q <= 32'h00000000;
            tlast_q <= 1'b0;
            tk_q <= 3'h0;
            tx_data_q <= 1'b1;
            rs_q <= RS_HUNT;
            rones_q <= 3'h0;
            rzeros_q <= 3'h0;
            rbcnt_q <= 3'h0;
            rsh_q <= 8'h00;
            rcrc_q <= 32'h00000000;
            rcnt_q <= 3'h0;
            fcnt_q <= 16'h0000;
            ahi_q <= 8'h00;
            afirst_q <= 1'b0;
            pend_v_q <= 1'b0;
            pend_d_q <= 9'h000;
            rxq_valid_q <= 1'b0;
            rxq_data_q <= 8'h00;
            rxq_status_q <= 1'b0;
            stat_crc_err_q <= 1'b0;
            stat_abort_q <= 1'b0;
        end else begin
            pin_s1_q <= {cts_n, tx_clk, rx_data, rx_clk};
            pin_s2_q <= pin_s1_q;
            rxc_prev_q <= pin_s2_q[0];
            txc_prev_q <= pin_s2_q[2];
            ts_q <= ts_d;
            tsh_q <= tsh_d;
            tbcnt_q <= tbcnt_d;
            tones_q <= tones_d;
            tzeros_q <= tzeros_d;
            tcrc_q <= tcrc_d;
            tlast_q <= tlast_d;
            tk_q <= tk_d;
            tx_data_q <= tbit_d;
            rs_q <= rs_d;
            rones_q <= rones_d;
            rzeros_q <= rzeros_d;
            rbcnt_q <= rbcnt_d;
            rsh_q <= rsh_d;
            rcrc_q <= rcrc_d;
            rcnt_q <= rcnt_d;
            fcnt_q <= fcnt_d;
            ahi_q <= ahi_d;
            afirst_q <= afirst_d;
            // Second word of a cycle waits one clock in the pending slot
            if (pend_v_q) begin
                rxq_valid_q <= 1'b1;
                {rxq_status_q, rxq_data_q} <= pend_d_q;
                pend_v_q <= em0_v;
                pend_d_q <= em0_d;
            end else begin
                rxq_valid_q <= em0_v | em1_v;
                {rxq_status_q, rxq_data_q} <= em0_v ? em0_d : em1_d;
                pend_v_q <= em0_v & em1_v;
                pend_d_q <= em1_d;
            end
            // Hardware set wins over a simultaneous clear
            stat_crc_err_q <= set_crc | (stat_crc_err_q & ~stat_clear);
            stat_abort_q <= set_abf | (stat_abort_q & ~stat_clear);
        end
    end

endmodule // hbf_framer

`default_nettype wire

// ==== test/hbf_framer_properties.sv ====
// Assertion checker on the framer's queue and status ports
`timescale 1ns/100ps
`default_nettype none
module hbf_chk (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       txq_valid,
    input wire logic       txq_ready,
    input wire logic       rxq_valid_q,
    input wire logic [7:0] rxq_data_q,
    input wire logic       rxq_status_q,
    input wire logic       stat_clear,
    input wire logic       stat_crc_err_q,
    input wire logic       stat_abort_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic sw;
    assign sw = rxq_valid_q && rxq_status_q;
    property p_rdy_one; txq_ready |=> !txq_ready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
    property p_rdy_req; txq_ready |-> txq_valid; endproperty
    a_rdy_req: assert property (p_rdy_req) else $error("ready with no byte");
    property p_sw_pad; sw |-> rxq_data_q[7:5] == 3'h0; endproperty
    a_sw_pad: assert property (p_sw_pad) else $error("status pad set");
    property p_sw_one; sw |=> !sw; endproperty
    a_sw_one: assert property (p_sw_one) else $error("status doubled");
    property p_ab_set; sw && rxq_data_q[2] |-> ##[0:2] stat_abort_q; endproperty
    a_ab_set: assert property (p_ab_set) else $error("abort flag low");
    property p_crc_set; sw && rxq_data_q[1] |-> ##[0:2] stat_crc_err_q; endproperty
    a_crc_set: assert property (p_crc_set) else $error("check flag low");
    property p_ab_hold; stat_abort_q && !stat_clear |=> stat_abort_q; endproperty
    a_ab_hold: assert property (p_ab_hold) else $error("abort flag lost");
    property p_vfr_ab; sw && rxq_data_q[0] |-> !rxq_data_q[2]; endproperty
    a_vfr_ab: assert property (p_vfr_ab) else $error("aborted yet valid");
endmodule // hbf_chk
bind hbf_framer hbf_chk hbf_chk_inst (.clk_sys, .resetn, .txq_valid, .txq_ready,
    .rxq_valid_q, .rxq_data_q, .rxq_status_q, .stat_clear, .stat_crc_err_q, .stat_abort_q);
`default_nettype wire

// ==== test/hbf_peer.sv ====
// Remote station: frames onto the receive pins, decodes the transmit pin
`timescale 1ns/100ps
`default_nettype none
module hbf_peer (
    output var logic rx_clk,
    output var logic rx_data,
    input wire logic tx_clk,
    input wire logic tx_data_q,
    output var logic cts_n
);
    int so = 0;
    int ro = 0;
    int nb = 0;
    bit fr = 0;
    logic [7:0] raw = 8'h00;
    logic [7:0] dat = 8'h00;
    logic [7:0] got[$];
    initial begin
        rx_clk = 1'b0;
        rx_data = 1'b1;
        cts_n = 1'b0;
    end
    task automatic put(input logic b);
        rx_data = b;
        #160 rx_clk = 1'b1;
        #160 rx_clk = 1'b0;
        so = b ? so + 1 : 0;
    endtask
    // Clock runs only inside frames; the idle line rests at marks
    task automatic send(input logic [7:0] b, input bit stuff);
        for (int i = 0; i < 8; i++) begin
            put(b[i]);
            if (stuff && so == 5) put(1'b0);
        end
        if (!stuff) so = 0;
        rx_data = 1'b1;
    endtask
    always @(posedge tx_clk) begin
        raw = {tx_data_q, raw[7:1]};
        if (raw == 8'h7E) begin
            fr = 1'b1;
            nb = 0;
        end else if (fr && !(tx_data_q == 1'b0 && ro == 5)) begin
            dat = {tx_data_q, dat[7:1]};
            nb++;
            if (nb == 8) begin
                got.push_back(dat);
                nb = 0;
            end
        end
        ro = tx_data_q ? ro + 1 : 0;
        if (ro > 6) fr = 1'b0;
    end
endmodule // hbf_peer
`default_nettype wire

// ==== test/hbf_framer_tb.sv ====
// Self-checking bench for the bit-oriented framer
`timescale 1ns/100ps
`default_nettype none
module hbf_framer_tb;
    logic clk_sys = 0, resetn = 0, tx_clk = 0, txq_valid = 0, txq_last = 0, stat_clear = 0;
    logic rx_reset_cmd = 0, cfg_one_ins = 0, cfg_addr_fwd = 1, cfg_rlc_en = 0, cfg_cts_en = 0;
    logic cfg_fill_marks = 1;
    logic [1:0] cfg_crc_sel = 2'h2, cfg_addr_mode = 2'h0;
    logic [7:0] txq_data = 8'h00;
    logic [15:0] cfg_station_addr = 0, cfg_station_mask = 0, cfg_rlc_len = 0;
    logic [15:0] cfg_group_addr = 0, cfg_group_mask = 0;
    wire rx_clk, rx_data, cts_n, tx_data_q, txq_ready, rxq_valid_q, rxq_status_q, rx_synced;
    wire stat_crc_err_q, stat_abort_q;
    wire [7:0] rxq_data_q;
    int mismatches = 0, comparisons = 0, cyc = 0;
    logic [8:0] rq[$];
    logic [7:0] av[5] = '{8'h34, 8'h52, 8'hFF, 8'hC3, 8'h00};
    bit ac[5] = '{0, 1, 1, 1, 0};
    hbf_framer hbf_framer_inst (.*);
    hbf_peer hbf_peer_inst (.*);
    initial forever #20 clk_sys = ~clk_sys;
    initial forever #160 tx_clk = ~tx_clk;
    always @(posedge clk_sys) begin
        cyc++;
        if (rxq_valid_q === 1'b1) rq.push_back({rxq_status_q, rxq_data_q});
        if (cyc == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, logic [8:0] s, logic [8:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmpq(input string n, logic [8:0] s[$], logic [8:0] e[$]);
        chk(n, 9'(s.size()), 9'(e.size()));
        foreach (e[k]) chk(n, s[k], e[k]);
        $display("test %s done", n);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [15:0] fcs(input logic [7:0] d[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (d[k])
            for (int i = 0; i < 8; i++)
                c = (c[0] ^ d[k][i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
        return ~c;
    endfunction
    // Bad flips one check bit; an aborted frame ends in eight ones; lim keeps that many bytes
    task automatic rx_case(input string n, logic [7:0] d[$], bit bad, ab, logic [8:0] st, bit acc,
                           int lim = 0);
        logic [15:0] f;
        logic [8:0] e[$];
        f = fcs(d) ^ {15'h0, bad};
        rq.delete();
        hbf_peer_inst.send(8'h7E, 0);
        foreach (d[k]) hbf_peer_inst.send(d[k], 1);
        hbf_peer_inst.send(ab ? 8'hFF : f[7:0], !ab);
        if (!ab) hbf_peer_inst.send(f[15:8], 1);
        if (!ab) d = {d, f[7:0], f[15:8]};
        while (lim > 0 && d.size() > lim) void'(d.pop_back());
        hbf_peer_inst.send(8'h7E, 0);
        repeat (20) @(posedge clk_sys);
        foreach (d[k]) e.push_back({1'b0, d[k]});
        e.push_back(st);
        if (!acc) e.delete();
        cmpq(n, rq, e);
    endtask
    // Receiver reset command in mid-frame closes it with a status word
    task automatic rx_stop_case();
        logic [8:0] e[$];
        rq.delete();
        hbf_peer_inst.send(8'h7E, 0);
        hbf_peer_inst.send(8'h52, 1);
        hbf_peer_inst.send(8'h11, 1);
        repeat (8) @(posedge clk_sys);
        chk("rx_stop_sync", {8'h00, rx_synced}, 9'h001);
        rx_reset_cmd <= 1'b1;
        @(posedge clk_sys);
        rx_reset_cmd <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("rx_stop_hunt", {8'h00, rx_synced}, 9'h000);
        e = '{9'h052, 9'h011, 9'h112};
        cmpq("rx_stop", rq, e);
    endtask
    // Clear-to-send held off: no byte may be taken
    task automatic tx_hold();
        int seen = 0;
        cfg_cts_en <= 1'b1;
        hbf_peer_inst.cts_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        txq_valid <= 1'b1;
        txq_data <= 8'hFF;
        repeat (200) @(negedge clk_sys) seen += txq_ready;
        @(posedge clk_sys);
        hbf_peer_inst.cts_n <= 1'b0;
        chk("tx_hold", 9'(seen), 9'h000);
        $display("test tx_hold done");
    endtask
    task automatic tx_case(input string n, logic [7:0] d[$]);
        logic [15:0] f;
        logic [8:0] s[$];
        logic [8:0] e[$];
        f = fcs(d);
        hbf_peer_inst.got.delete();
        foreach (d[k]) begin
            txq_valid <= 1'b1;
            txq_data <= d[k];
            txq_last <= (k == d.size() - 1);
            do @(negedge clk_sys); while (txq_ready !== 1'b1);
            @(posedge clk_sys);
        end
        txq_valid <= 1'b0;
        d = {d, f[7:0], f[15:8]};
        while (hbf_peer_inst.got.size() < d.size()) @(posedge clk_sys);
        foreach (d[k]) e.push_back({1'b0, d[k]});
        foreach (hbf_peer_inst.got[k]) s.push_back({1'b0, hbf_peer_inst.got[k]});
        cmpq(n, s, e);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rx_reset_cmd <= 1'b1;
        @(posedge clk_sys);
        rx_reset_cmd <= 1'b0;
        rx_case("rx_stuff", '{8'hFF, 8'h7E, 8'hF8, 8'h1F}, 0, 0, 9'h101, 1);
        rx_case("rx_crc", '{8'hA5, 8'h5A, 8'h0F}, 1, 0, 9'h103, 1);
        rx_case("rx_abort", '{8'h12, 8'h34, 8'h56}, 0, 1, 9'h106, 1);
        chk("sticky", {7'h0, stat_crc_err_q, stat_abort_q}, 9'h003);
        stat_clear <= 1'b1;
        {cfg_addr_mode, cfg_station_addr, cfg_station_mask, cfg_group_addr, cfg_group_mask}
            <= {2'h1, 16'hAB12, 16'h00F0, 16'h00C3, 16'h0001};
        @(posedge clk_sys);
        stat_clear <= 1'b0;
        @(posedge clk_sys);
        chk("cleared", {7'h0, stat_crc_err_q, stat_abort_q}, 9'h000);
        foreach (av[k]) rx_case("rx_addr", '{av[k], 8'h11, 8'h22}, 0, 0, 9'h101, ac[k]);
        rx_stop_case();
        cfg_addr_mode <= 2'h2;
        rx_case("rx_a16", '{8'hAB, 8'h52, 8'h11}, 0, 0, 9'h101, 1);
        rx_case("rx_a16", '{8'hAC, 8'h12, 8'h11}, 0, 0, 9'h101, 0);
        rx_case("rx_a16", '{8'hFF, 8'h99, 8'h11}, 0, 0, 9'h101, 1);
        rx_case("rx_a16", '{8'h00, 8'hC3, 8'h11}, 0, 0, 9'h101, 0);
        {cfg_rlc_en, cfg_rlc_len} <= {1'b1, 16'h0003};
        rx_case("rx_len", '{8'hAB, 8'h52, 8'h11, 8'h22}, 0, 0, 9'h108, 1, 3);
        cfg_fill_marks <= 1'b0;
        tx_hold();
        tx_case("tx_frame", '{8'hFF, 8'h7C, 8'h3F, 8'h01});
        report_and_stop();
    end
endmodule // hbf_framer_tb
`default_nettype wire
